// File: rcg_counter.sv
// One gated, retriggerable counter channel with its mode register
//
// Functional notes
// - Strobe mode starts only on a gate edge reaching an armed counter.
// - Strobe mode counts ungated to first terminal count, reloads, disarms.
// - Strobe mode armed gate edges save count to hold; next edge reloads.
// - Rate mode counts gated edges, reloads from load at each terminal count.
// - Rate mode gate edge saves count; next qualified edge reloads from load.
// - One-shot starts on armed gate edge, counts ungated, reloads, stops.
// - One-shot armed gate edges save count; next source edge reloads from load.
// - Gate-select mode: low gate picks load, high picks hold, for all reloads.
// - Gate-select mode reaches terminal count twice then disarms.
// - FSK mode counts repeatedly, gate picks reload source until disarmed.
// - Save mode gate edges while counting copy count to hold, no restart.
// - Save mode counts to terminal count, reloads, stops; resumes next edge.
// - Counter has its own 16-bit mode register.
// - Mode register resets to 0800 hex.
// - Terminal count follows 0001 down, 9999 BCD up, FFFF binary up.
// - Toggled output flips on trailing edge of each terminal count.
`timescale 1ns/1ps
`default_nettype none
module rcg_counter
    import rcg_pkg::*;
(
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic gatePin,
    input wire logic sourcePin,
    input wire logic [2:0] regAddr,
    input wire logic [15:0] regWrData,
    input wire logic regWrStb,
    input wire logic regRdStb,
    output logic [15:0] regRdData,
    output logic counterOut,
    output logic terminalCount,
    output logic armed
);
    ////////////////////////////////////////////////////////////////////////////
    logic gateLvl;
    logic gateRise;
    logic gateFall;
    logic srcRise;
    logic srcFall;

    rcg_sync_edge uGateSync (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .asyncIn(gatePin),
        .level(gateLvl),
        .rise(gateRise),
        .fall(gateFall)
    );

    rcg_sync_edge uSrcSync (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .asyncIn(sourcePin),
        .level(),
        .rise(srcRise),
        .fall(srcFall)
    );

    ////////////////////////////////////////////////////////////////////////////
    logic [15:0] counterModeBits_q;
    logic [15:0] load_q;
    logic [15:0] hold_q;
    logic [15:0] count_q;
    logic armed_q;
    logic running_q;
    logic retrig_q;
    logic secondTc_q;
    logic tc_q;
    logic toggle_q;
    logic out_q;
    logic [15:0] rdData_q;
    rcg_mode_e mode;

    logic [2:0] gating;
    logic gateActive;
    logic gateEdge;
    logic srcEdge;
    logic wrCmd;
    logic cmdArm;
    logic cmdDisarm;
    logic cmdLoad;
    logic cmdReset;
    logic gateSelMode;
    logic qualified;
    logic atLast;
    logic tcEvent;
    logic [15:0] reloadVal;
    logic [15:0] stepVal;

    assign gating = counterModeBits_q[GATE_HI:GATE_LO];
    // Polarity bit inverts the gate sense and the counted source edge
    assign gateActive = counterModeBits_q[EDGE_POL_BIT] ? ~gateLvl : gateLvl;
    assign gateEdge = counterModeBits_q[EDGE_POL_BIT] ? gateFall : gateRise;
    assign srcEdge = counterModeBits_q[EDGE_POL_BIT] ? srcFall : srcRise;
    assign wrCmd = regWrStb && (regAddr == ADDR_CMD);
    assign cmdArm = wrCmd && regWrData[CMD_ARM];
    assign cmdDisarm = wrCmd && regWrData[CMD_DISARM];
    assign cmdLoad = wrCmd && regWrData[CMD_LOAD];
    assign cmdReset = wrCmd && regWrData[CMD_RESET];

    // Mode decode from gating, special, reload-select and repeat bits
    always_comb begin
        mode = RCG_M_OTHER;
        if (counterModeBits_q[SPECIAL_BIT]) begin
            unique case ({gating != GATE_NONE, counterModeBits_q[RELOAD_SEL_BIT],
                          counterModeBits_q[REPEAT_BIT]})
                3'h4: mode = RCG_M_STROBE;
                3'h5: mode = RCG_M_RATE;
                3'h2: mode = RCG_M_GATESEL;
                3'h3: mode = RCG_M_FSK;
                3'h7: mode = RCG_M_SAVE;
                default: mode = RCG_M_OTHER;
            endcase
            // Edge gating with repeat and load reload is the one-shot
            if (mode == RCG_M_RATE && gating[0] == 1'b0 && gating != GATE_NONE) begin
                mode = RCG_M_ONESHOT;
            end
        end
    end

    assign gateSelMode = (mode == RCG_M_GATESEL) || (mode == RCG_M_FSK);
    // Low gate picks load, high gate picks hold
    assign reloadVal = (gateSelMode && gateLvl) ? hold_q : load_q;

    // A source edge counts only when the mode allows it
    always_comb begin
        qualified = 1'b0;
        unique case (mode)
            RCG_M_RATE: qualified = srcEdge && armed_q && gateActive;
            RCG_M_STROBE, RCG_M_ONESHOT, RCG_M_SAVE:
                qualified = srcEdge && running_q;
            RCG_M_GATESEL, RCG_M_FSK, RCG_M_OTHER:
                qualified = srcEdge && armed_q;
        endcase
        // The edge that ends terminal count is always counted
        if (tc_q && srcEdge) begin
            qualified = 1'b1;
        end
    end

    // Terminal count is committed when the counter sits at its last value
    always_comb begin
        if (!counterModeBits_q[UP_BIT]) begin
            atLast = (count_q == CNT_ONE);
        end else if (counterModeBits_q[BCD_BIT]) begin
            atLast = (count_q == CNT_BCD_MAX);
        end else begin
            atLast = (count_q == CNT_BIN_MAX);
        end
    end
    assign tcEvent = qualified && !retrig_q && atLast;

    // Next count value, binary or BCD, up or down
    function automatic logic [15:0] step(input logic [15:0] v, input logic up,
                                         input logic bcd);
        logic [15:0] r;
        logic carry;
        r = v;
        carry = 1'b1;
        if (!bcd) begin
            r = up ? v + 16'h0001 : v - 16'h0001;
        end else begin
            for (int i = 0; i < 4; i++) begin
                if (carry) begin
                    if (up) begin
                        carry = (v[i*4 +: 4] == BCD_DIGIT_MAX);
                        r[i*4 +: 4] = carry ? BCD_DIGIT_ZERO : v[i*4 +: 4] + 4'h1;
                    end else begin
                        carry = (v[i*4 +: 4] == BCD_DIGIT_ZERO);
                        r[i*4 +: 4] = carry ? BCD_DIGIT_MAX : v[i*4 +: 4] - 4'h1;
                    end
                end
            end
        end
        return r;
    endfunction
    assign stepVal = step(count_q, counterModeBits_q[UP_BIT], counterModeBits_q[BCD_BIT]);

    ////////////////////////////////////////////////////////////////////////////
    // Mode register; software should only change it while disarmed
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            counterModeBits_q <= MODE_RESET;
        end else if (cmdReset) begin
            counterModeBits_q <= MODE_RESET;
        end else if (regWrStb && regAddr == ADDR_MODE) begin
            counterModeBits_q <= regWrData;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            load_q <= '0;
        end else if (regWrStb && regAddr == ADDR_LOAD) begin
            load_q <= regWrData;
        end
    end

    // Hold register: software write or gate-edge save
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            hold_q <= '0;
        end else if (gateEdge && mode == RCG_M_RATE) begin
            hold_q <= count_q;
        end else if (gateEdge && armed_q && (mode == RCG_M_STROBE
                     || mode == RCG_M_ONESHOT)) begin
            hold_q <= count_q;
        end else if (gateEdge && running_q && mode == RCG_M_SAVE) begin
            hold_q <= count_q;
        end else if (regWrStb && regAddr == ADDR_HOLD) begin
            hold_q <= regWrData;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Arm state; self-disarm at end of cycle, host arm/disarm
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            armed_q <= 1'b0;
        end else if (cmdDisarm || cmdReset) begin
            armed_q <= 1'b0;
        end else if (cmdArm) begin
            armed_q <= 1'b1;
        end else if (tcEvent && mode == RCG_M_STROBE) begin
            armed_q <= 1'b0;
        end else if (tcEvent && mode == RCG_M_GATESEL && secondTc_q) begin
            armed_q <= 1'b0;
        end else if (tcEvent && !counterModeBits_q[REPEAT_BIT]
                     && mode == RCG_M_OTHER) begin
            armed_q <= 1'b0;
        end
    end

    // Edge-started modes run from an armed gate edge to terminal count
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            running_q <= 1'b0;
        end else if (!armed_q || cmdDisarm || cmdReset) begin
            running_q <= 1'b0;
        end else if (tcEvent) begin
            running_q <= 1'b0;
        end else if (gateEdge) begin
            running_q <= 1'b1;
        end
    end

    // Pending retrigger: next qualified edge loads instead of counting
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            retrig_q <= 1'b0;
        end else if (cmdDisarm || cmdReset) begin
            retrig_q <= 1'b0;
        end else if (gateEdge && ((armed_q && (mode == RCG_M_STROBE
                     || mode == RCG_M_ONESHOT)) || mode == RCG_M_RATE)) begin
            retrig_q <= 1'b1;
        end else if (qualified) begin
            retrig_q <= 1'b0;
        end
    end

    // Gate-select mode counts which terminal count of the pair is next
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            secondTc_q <= 1'b0;
        end else if (cmdArm || cmdReset) begin
            secondTc_q <= 1'b0;
        end else if (tcEvent && mode == RCG_M_GATESEL) begin
            secondTc_q <= ~secondTc_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Counter: load command, retrigger load, reload at terminal count, count
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            count_q <= '0;
        end else if (cmdReset) begin
            count_q <= '0;
        end else if (cmdLoad) begin
            count_q <= reloadVal;
        end else if (qualified && retrig_q) begin
            count_q <= load_q;
        end else if (tcEvent) begin
            count_q <= reloadVal;
        end else if (qualified) begin
            count_q <= stepVal;
        end
    end

    // Terminal count lasts one source period: set on the commit, cleared next edge
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            tc_q <= 1'b0;
        end else if (tcEvent) begin
            tc_q <= 1'b1;
        end else if (qualified || cmdReset) begin
            tc_q <= 1'b0;
        end
    end

    // Toggle flips when terminal count ends
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            toggle_q <= 1'b0;
        end else if (cmdReset) begin
            toggle_q <= 1'b0;
        end else if (tc_q && qualified && !tcEvent) begin
            toggle_q <= ~toggle_q;
        end else if (tc_q && tcEvent) begin
            toggle_q <= ~toggle_q;
        end
    end

    // Output forms; other codes drive low
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            out_q <= 1'b0;
        end else begin
            unique case (counterModeBits_q[OUT_HI:OUT_LO])
                OUT_PULSE_HI: out_q <= tcEvent || (tc_q && !qualified);
                OUT_PULSE_LO: out_q <= !(tcEvent || (tc_q && !qualified));
                OUT_TOGGLE: out_q <= (tc_q && qualified) ? ~toggle_q : toggle_q;
                default: out_q <= 1'b0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            rdData_q <= '0;
        end else if (regRdStb) begin
            unique case (regAddr)
                ADDR_MODE: rdData_q <= counterModeBits_q;
                ADDR_LOAD: rdData_q <= load_q;
                ADDR_HOLD: rdData_q <= hold_q;
                ADDR_COUNT: rdData_q <= count_q;
                ADDR_STATUS: rdData_q <= {12'h000, toggle_q, tc_q, running_q, armed_q};
                default: rdData_q <= '0;
            endcase
        end else begin
            rdData_q <= '0;
        end
    end

    assign regRdData = rdData_q;
    assign counterOut = out_q;
    assign terminalCount = tc_q;
    assign armed = armed_q;
endmodule
`default_nettype wire

// File: rcg_pkg.sv
// Constants, field layout and mode encodings for the gated counter channel
package rcg_pkg;
    localparam int CNT_W = 16;
    localparam logic [15:0] MODE_RESET = 16'h0800;
    // Mode register field positions
    localparam int OUT_LO = 0;
    localparam int OUT_HI = 2;
    localparam int BCD_BIT = 3;
    localparam int UP_BIT = 4;
    localparam int REPEAT_BIT = 5;
    localparam int RELOAD_SEL_BIT = 6;
    localparam int SPECIAL_BIT = 7;
    localparam int SRC_LO = 8;
    localparam int SRC_HI = 11;
    localparam int EDGE_POL_BIT = 12;
    localparam int GATE_LO = 13;
    localparam int GATE_HI = 15;
    // Output control codes
    localparam logic [2:0] OUT_TOGGLE = 3'h2;
    localparam logic [2:0] OUT_PULSE_HI = 3'h1;
    localparam logic [2:0] OUT_PULSE_LO = 3'h5;
    // Gating control: zero means no gating; other values gate only in the strobe, rate, one-shot and save modes
    localparam logic [2:0] GATE_NONE = 3'h0;
    // Counting limits
    localparam logic [15:0] CNT_ONE = 16'h0001;
    localparam logic [15:0] CNT_BIN_MAX = 16'hFFFF;
    localparam logic [15:0] CNT_BCD_MAX = 16'h9999;
    localparam logic [3:0] BCD_DIGIT_MAX = 4'h9;
    localparam logic [3:0] BCD_DIGIT_ZERO = 4'h0;
    // Software register map of the plain port
    localparam logic [2:0] ADDR_MODE = 3'h0;
    localparam logic [2:0] ADDR_LOAD = 3'h1;
    localparam logic [2:0] ADDR_HOLD = 3'h2;
    localparam logic [2:0] ADDR_COUNT = 3'h3;
    localparam logic [2:0] ADDR_CMD = 3'h4;
    localparam logic [2:0] ADDR_STATUS = 3'h5;
    // Command bits written to ADDR_CMD
    localparam int CMD_ARM = 0;
    localparam int CMD_DISARM = 1;
    localparam int CMD_LOAD = 2;
    localparam int CMD_RESET = 3;
    // Operating modes decoded from the mode register
    typedef enum logic [2:0] {
        RCG_M_OTHER, RCG_M_STROBE, RCG_M_RATE, RCG_M_ONESHOT,
        RCG_M_GATESEL, RCG_M_FSK, RCG_M_SAVE
    } rcg_mode_e;
endpackage

// File: rcg_sync_edge.sv
// Two-stage synchroniser with rising and falling edge pulses
`timescale 1ns/1ps
`default_nettype none
module rcg_sync_edge (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic asyncIn,
    output logic level,
    output logic rise,
    output logic fall
);
    logic meta_q;
    logic sync_q;
    logic last_q;

    // First stage is read only by the second stage
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            last_q <= 1'b0;
        end else begin
            meta_q <= asyncIn;
            sync_q <= meta_q;
            last_q <= sync_q;
        end
    end

    assign level = sync_q;
    assign rise = sync_q & ~last_q;
    assign fall = ~sync_q & last_q;
endmodule
`default_nettype wire

// File: rcg_counter_asserts.sv
// Port-level checker for the gated counter channel
`timescale 1ns/1ps
`default_nettype none
module rcg_counter_asserts
    import rcg_pkg::*;
(
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic gatePin,
    input wire logic sourcePin,
    input wire logic [2:0] regAddr,
    input wire logic [15:0] regWrData,
    input wire logic regWrStb,
    input wire logic regRdStb,
    input wire logic [15:0] regRdData,
    input wire logic counterOut,
    input wire logic terminalCount,
    input wire logic armed
);
    logic srcPrev_q;
    logic [3:0] srcAge_q;
    logic [3:0] wrAge_q;
    logic modeTouched_q;
    ////////////////////////////////////////////////////////////////////////
    // Ages let state changes be tied to the pin or write that caused them
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            srcPrev_q <= 1'b0;
            srcAge_q <= 4'hF;
        end else begin
            srcPrev_q <= sourcePin;
            if (sourcePin != srcPrev_q) begin
                srcAge_q <= 4'h0;
            end else if (srcAge_q != 4'hF) begin
                srcAge_q <= srcAge_q + 4'h1;
            end
        end
    end
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            wrAge_q <= 4'hF;
        end else if (regWrStb) begin
            wrAge_q <= 4'h0;
        end else if (wrAge_q != 4'hF) begin
            wrAge_q <= wrAge_q + 4'h1;
        end
    end
    // Master reset command brings the default back, so it clears the flag
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            modeTouched_q <= 1'b0;
        end else if (regWrStb && regAddr == ADDR_MODE) begin
            modeTouched_q <= 1'b1;
        end else if (regWrStb && regAddr == ADDR_CMD && regWrData[CMD_RESET]) begin
            modeTouched_q <= 1'b0;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!arst_n);
    chk_rd_idle_zero: assert property (!regRdStb |=> regRdData == 16'h0000)
        else $error("read data not zero outside a read");
    chk_rd_unmapped: assert property (regRdStb && regAddr > ADDR_STATUS |=> regRdData == 16'h0000)
        else $error("unmapped read not zero");
    chk_mode_default: assert property (
        regRdStb && regAddr == ADDR_MODE && !modeTouched_q |=> regRdData == MODE_RESET)
        else $error("mode register default wrong");
    chk_mode_readback: assert property (regWrStb && regAddr == ADDR_MODE ##2
        regRdStb && regAddr == ADDR_MODE |=> regRdData == $past(regWrData, 3))
        else $error("mode register readback wrong");
    chk_arm_takes: assert property (regWrStb && regAddr == ADDR_CMD && regWrData[CMD_ARM]
        && !regWrData[CMD_DISARM] && !regWrData[CMD_RESET] |-> ##[1:2] armed)
        else $error("arm command did not arm");
    chk_arm_from_host: assert property ($rose(armed) |-> wrAge_q <= 4'h3)
        else $error("armed rose without a host write");
    chk_disarm_cause: assert property ($fell(armed) |-> srcAge_q <= 4'h6 || wrAge_q <= 4'h3)
        else $error("armed fell without source edge or command");
    chk_tc_on_source: assert property ($changed(terminalCount) |-> srcAge_q <= 4'h6)
        else $error("terminal count changed away from a source edge");
    chk_out_cause: assert property ($changed(counterOut) |-> srcAge_q <= 4'h6 || wrAge_q <= 4'h3)
        else $error("output changed without cause");
    cov_tc: cover property ($rose(terminalCount));
    cov_disarm: cover property ($fell(armed));
    cov_toggle: cover property ($rose(counterOut));
endmodule
`default_nettype wire

// File: rcg_pin_model.sv
// Far-side model: drives the gate level and count source pulses
`timescale 1ns/1ps
`default_nettype none
module rcg_pin_model (
    input wire logic ref_clk,
    output logic gatePin,
    output logic sourcePin
);
    initial begin
        gatePin = 1'b0;
        sourcePin = 1'b0;
    end
    // Four cycles high and low keeps each edge clear of the two-flop sync
    task automatic src(input int n);
        repeat (n) begin
            sourcePin <= 1'b1;
            repeat (4) @(posedge ref_clk);
            sourcePin <= 1'b0;
            repeat (4) @(posedge ref_clk);
        end
        repeat (2) @(posedge ref_clk);
    endtask
    task automatic gate(input logic v);
        gatePin <= v;
        repeat (6) @(posedge ref_clk);
    endtask
endmodule
`default_nettype wire

// File: rcg_testbench.sv
// Self-checking bench for the gated counter channel
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import rcg_pkg::*;
    logic ref_clk;
    logic arst_n;
    logic gatePin;
    logic sourcePin;
    logic [2:0] regAddr;
    logic [15:0] regWrData;
    logic regWrStb;
    logic regRdStb;
    logic [15:0] regRdData;
    logic counterOut;
    logic terminalCount;
    logic armed;
    logic co0;
    int fails;
    int nCompared;
    int cycles = 0;
    rcg_counter rcg_counter_i (.ref_clk(ref_clk), .arst_n(arst_n), .gatePin(gatePin),
        .sourcePin(sourcePin), .regAddr(regAddr), .regWrData(regWrData), .regWrStb(regWrStb),
        .regRdStb(regRdStb), .regRdData(regRdData), .counterOut(counterOut),
        .terminalCount(terminalCount), .armed(armed));
    rcg_pin_model rcg_pin_model_i (.ref_clk(ref_clk), .gatePin(gatePin), .sourcePin(sourcePin));
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        nCompared++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Strobe is lowered a cycle later so no signal is driven twice in one step
    task automatic wr(input logic [2:0] a, input logic [15:0] d);
        regAddr <= a;
        regWrData <= d;
        regWrStb <= 1'b1;
        @(posedge ref_clk);
        regWrStb <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic rc(input logic [2:0] a, input logic [15:0] e, input string what);
        logic [15:0] v;
        regAddr <= a;
        regRdStb <= 1'b1;
        @(posedge ref_clk);
        regRdStb <= 1'b0;
        #1;
        v = regRdData;
        chk(what, v, e);
        @(posedge ref_clk);
    endtask
    task automatic pin(input string what, input logic seen, input logic e);
        chk(what, {15'h0000, seen}, {15'h0000, e});
    endtask
    task automatic cmd(input logic [15:0] bits);
        wr(ADDR_CMD, bits);
    endtask
    task automatic src(input int n);
        rcg_pin_model_i.src(n);
    endtask
    task automatic gate(input logic v);
        rcg_pin_model_i.gate(v);
    endtask
    task automatic give_verdict();
        $display("compared %0d failed %0d", nCompared, fails);
        if (fails == 0 && nCompared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fails++;
            give_verdict();
        end
    end
    initial begin
        fails = 0;
        nCompared = 0;
        arst_n = 1'b0;
        regAddr = 3'h0;
        regWrData = 16'h0000;
        regWrStb = 1'b0;
        regRdStb = 1'b0;
        repeat (8) @(posedge ref_clk);
        arst_n <= 1'b1;
        @(posedge ref_clk);
        rc(ADDR_MODE, 16'h0800, "mode reset");
        rc(3'h7, 16'h0000, "unmapped");
        wr(ADDR_MODE, 16'h1234);
        rc(ADDR_MODE, 16'h1234, "mode rw");
        cmd(16'h0008);
        rc(ADDR_MODE, 16'h0800, "mode master reset");
        // Edge-started retriggerable strobe
        wr(ADDR_MODE, 16'h4880);
        wr(ADDR_LOAD, 16'h0003);
        cmd(16'h0004);
        wr(ADDR_HOLD, 16'h0055);
        gate(1'b1);
        rc(ADDR_HOLD, 16'h0055, "strobe disarmed edge");
        gate(1'b0);
        cmd(16'h0001);
        src(1);
        rc(ADDR_COUNT, 16'h0003, "strobe armed untriggered");
        wr(ADDR_LOAD, 16'h0002);
        gate(1'b1);
        rc(ADDR_HOLD, 16'h0003, "strobe save");
        gate(1'b0);
        src(1);
        rc(ADDR_COUNT, 16'h0002, "strobe retrigger load");
        src(1);
        rc(ADDR_COUNT, 16'h0001, "strobe count gate low");
        src(1);
        rc(ADDR_COUNT, 16'h0002, "strobe tc reload");
        pin("strobe disarm", armed, 1'b0);
        // Terminal count always takes its closing edge, armed or not
        src(1);
        rc(ADDR_COUNT, 16'h0001, "strobe tc end counts");
        // Level-gated rate generator
        wr(ADDR_MODE, 16'h28A0);
        wr(ADDR_LOAD, 16'h0002);
        cmd(16'h0004);
        wr(ADDR_LOAD, 16'h0004);
        cmd(16'h0001);
        src(2);
        rc(ADDR_COUNT, 16'h0002, "rate gated off");
        gate(1'b1);
        rc(ADDR_HOLD, 16'h0002, "rate save");
        src(2);
        gate(1'b0);
        src(2);
        rc(ADDR_COUNT, 16'h0003, "rate pause");
        gate(1'b1);
        rc(ADDR_HOLD, 16'h0003, "rate resave");
        src(1);
        rc(ADDR_COUNT, 16'h0004, "rate reload");
        src(4);
        rc(ADDR_COUNT, 16'h0004, "rate tc reload");
        pin("rate stays armed", armed, 1'b1);
        // Rate terminal count end while disarmed, then retriggerable one-shot
        cmd(16'h0002);
        src(1);
        rc(ADDR_COUNT, 16'h0003, "rate tc end counts disarmed");
        wr(ADDR_MODE, 16'h48A0);
        wr(ADDR_LOAD, 16'h0003);
        cmd(16'h0004);
        gate(1'b0);
        cmd(16'h0001);
        src(1);
        rc(ADDR_COUNT, 16'h0003, "oneshot untriggered");
        gate(1'b1);
        rc(ADDR_HOLD, 16'h0003, "oneshot save");
        src(2);
        gate(1'b0);
        gate(1'b1);
        rc(ADDR_HOLD, 16'h0002, "oneshot resave");
        src(1);
        rc(ADDR_COUNT, 16'h0003, "oneshot reload");
        src(3);
        rc(ADDR_COUNT, 16'h0003, "oneshot tc reload");
        // Gate-selected reload source, two terminal counts
        cmd(16'h0002);
        wr(ADDR_MODE, 16'h08C0);
        wr(ADDR_LOAD, 16'h0005);
        wr(ADDR_HOLD, 16'h0009);
        gate(1'b0);
        cmd(16'h0004);
        rc(ADDR_COUNT, 16'h0005, "gatesel low load");
        gate(1'b1);
        cmd(16'h0004);
        rc(ADDR_COUNT, 16'h0009, "gatesel high load");
        cmd(16'h0001);
        src(9);
        rc(ADDR_COUNT, 16'h0009, "gatesel first tc");
        pin("gatesel armed", armed, 1'b1);
        gate(1'b0);
        src(9);
        rc(ADDR_COUNT, 16'h0005, "gatesel second tc");
        pin("gatesel disarm", armed, 1'b0);
        src(1);
        rc(ADDR_COUNT, 16'h0004, "gatesel tc end counts");
        // Frequency-shift keying with toggled output
        wr(ADDR_MODE, 16'h08E2);
        wr(ADDR_LOAD, 16'h0002);
        wr(ADDR_HOLD, 16'h0003);
        cmd(16'h0004);
        cmd(16'h0001);
        co0 = counterOut;
        src(2);
        rc(ADDR_COUNT, 16'h0002, "fsk low reload");
        pin("tc active", terminalCount, 1'b1);
        pin("toggle held in tc", counterOut, co0);
        src(1);
        pin("toggle at tc end", counterOut, ~co0);
        pin("tc ended", terminalCount, 1'b0);
        gate(1'b1);
        src(1);
        rc(ADDR_COUNT, 16'h0003, "fsk high reload");
        src(1);
        pin("toggle back", counterOut, co0);
        cmd(16'h0002);
        src(2);
        rc(ADDR_COUNT, 16'h0002, "fsk disarmed");
        // Hardware save
        wr(ADDR_MODE, 16'h48E0);
        wr(ADDR_LOAD, 16'h0004);
        cmd(16'h0005);
        gate(1'b0);
        src(1);
        rc(ADDR_COUNT, 16'h0004, "save untriggered");
        gate(1'b1);
        src(1);
        rc(ADDR_COUNT, 16'h0003, "save first edge counts");
        gate(1'b0);
        gate(1'b1);
        rc(ADDR_HOLD, 16'h0003, "save capture");
        src(1);
        rc(ADDR_COUNT, 16'h0002, "save no restart");
        src(2);
        rc(ADDR_COUNT, 16'h0004, "save tc reload");
        // Plain BCD up count, count once, pulse output
        cmd(16'h0002);
        wr(ADDR_MODE, 16'h0019);
        wr(ADDR_LOAD, 16'h9998);
        cmd(16'h0005);
        src(2);
        rc(ADDR_COUNT, 16'h9998, "bcd up tc reload");
        pin("bcd tc active", terminalCount, 1'b1);
        pin("pulse out in tc", counterOut, 1'b1);
        pin("count once disarm", armed, 1'b0);
        give_verdict();
    end
endmodule
bind rcg_counter rcg_counter_asserts rcg_counter_asserts_i (.ref_clk(ref_clk), .arst_n(arst_n),
    .gatePin(gatePin), .sourcePin(sourcePin), .regAddr(regAddr), .regWrData(regWrData),
    .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData), .counterOut(counterOut),
    .terminalCount(terminalCount), .armed(armed));
`default_nettype wire
